// file: bench/fp_error_signalling_tb.sv
// Self-checking bench for the floating-point error signalling core
module fp_error_signalling_tb;
    import fpes_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, arst_n = 1'b0, mode, bv, raise, masked, mmf, we, io_wr, slow;
    fpes_class_e cls;
    logic [7:0]  mmv, io_addr, vn;
    logic [2:0]  wi, ri;
    logic [63:0] wd, rd;
    logic        irq, ign_n, err_n, stall, vv;
    int          bad_count = 0, n_compared = 0;
    always #25 clk = ~clk;
    fpes_core dut (.clk(clk), .arst_n(arst_n), .numeric_error_mode_bit(mode), .ignore_numeric_err_in_n(ign_n),
        .maskable_irq_in(irq), .boundary_valid(bv), .boundary_class(cls), .exc_raise(raise), .exc_masked(masked),
        .mm_fault(mmf), .mm_fault_vector(mmv), .stack_wr_en(we), .stack_wr_idx(wi), .stack_wr_data(wd),
        .stack_rd_idx(ri), .stack_rd_data(rd), .fp_error_out_n(err_n), .exec_stall(stall),
        .vector_valid(vv), .vector_num(vn));
    fpes_glue_model glue (.clk(clk), .rst_n(arst_n), .fp_error_out_n(err_n), .io_wr(io_wr),
        .io_addr(io_addr), .slow(slow), .maskable_irq_in(irq), .ignore_numeric_err_in_n(ign_n));
    ////////////////////////////////////////
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic bnd(input fpes_class_e c, input logic r);
        @(posedge clk);
        bv <= 1'b1; cls <= c; raise <= r;
        @(posedge clk);
        bv <= 1'b0; raise <= 1'b0;
        #1;
    endtask
    task automatic io(input logic [7:0] a);
        @(posedge clk);
        io_wr <= 1'b1; io_addr <= a;
        @(posedge clk);
        io_wr <= 1'b0;
        #1;
    endtask
    // Bounded wait: 0 stall, 1 error pin, 2 vector pulse
    task automatic wait_for(input int sel, input logic v, input int lim);
        logic s;
        for (int k = 0; k <= lim; k++) begin
            case (sel)
                0: s = stall;
                1: s = err_n;
                default: s = vv;
            endcase
            if (s === v) return;
            tick(1);
        end
    endtask
    ////////////////////////////////////////
    task automatic t_self;
        @(posedge clk);
        mode <= 1'b1;
        bnd(FPES_CLS_FP, 1'b1);
        bnd(FPES_CLS_WAIT, 1'b0);
        wait_for(2, 1'b1, 6);
        chk(vv, 1); chk(vn, FPES_FP_VECTOR);
        chk(err_n, 1); chk(stall, 0);
        $display("self vector test done");
    endtask
    task automatic t_ext(input logic s);
        @(posedge clk);
        mode <= 1'b0; slow <= s;
        bnd(FPES_CLS_FP, 1'b1);
        tick(4); chk(err_n, 1);
        bnd(FPES_CLS_MM_INT, 1'b0);
        wait_for(0, 1'b1, 4); chk(stall, 1);
        wait_for(1, 1'b0, 4); chk(err_n, 0); chk(vv, 0);
        wait_for(0, 1'b0, 8); chk(stall, 0); chk(err_n, 0); chk(irq, 1);
        io(8'hf1); tick(6); chk(err_n, 0);
        io(8'hf0); tick(3); chk(err_n, 0);
        bnd(FPES_CLS_WAIT, 1'b0); wait_for(1, 1'b1, 8); chk(err_n, 1);
        tick(3); chk(ign_n, 1); chk(irq, 0);
        $display("external path test done");
    endtask
    // Ignore reaches the core in the same cycle as the slow interrupt and wins
    task automatic t_ignore;
        @(posedge clk);
        mode <= 1'b0; slow <= 1'b1;
        bnd(FPES_CLS_FP, 1'b1);
        bnd(FPES_CLS_WAIT, 1'b0);
        wait_for(1, 1'b0, 4); chk(err_n, 0); chk(stall, 1);
        io(8'hf0); wait_for(1, 1'b1, 8); chk(err_n, 1); chk(stall, 0);
        tick(3); chk(ign_n, 1); chk(irq, 0);
        $display("ignore during stall test done");
    endtask
    task automatic t_packed;
        bnd(FPES_CLS_MM_FLT, 1'b1);
        bnd(FPES_CLS_MM_INT, 1'b1);
        @(posedge clk);
        masked <= 1'b1;
        bnd(FPES_CLS_FP, 1'b1);
        @(posedge clk);
        masked <= 1'b0;
        bnd(FPES_CLS_WAIT, 1'b0);
        tick(6); chk(stall, 0); chk(err_n, 1);
        $display("packed test done");
    endtask
    task automatic t_fault;
        @(posedge clk);
        mmf <= 1'b1; mmv <= FPES_DNA_VECTOR;
        @(posedge clk);
        mmf <= 1'b0;
        #1;
        wait_for(2, 1'b1, 4); chk(vv, 1); chk(vn, FPES_DNA_VECTOR);
        $display("fault vector test done");
    endtask
    task automatic t_stack;
        for (int i = 0; i < FPES_MM_REGS; i++) begin
            @(posedge clk);
            we <= 1'b1; wi <= 3'(i); wd <= {8{5'h0a, 3'(i)}};
        end
        @(posedge clk);
        we <= 1'b0;
        for (int i = FPES_MM_REGS - 1; i >= 0; i--) begin
            @(posedge clk);
            ri <= 3'(i);
            tick(1); chk(rd, {8{5'h0a, 3'(i)}});
        end
        $display("stack test done");
    endtask
    task automatic stop_test;
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        {mode, bv, raise, masked, mmf, we, io_wr, slow} = '0;
        cls = FPES_CLS_OTHER; mmv = '0; io_addr = '0; wi = '0; ri = '0; wd = '0;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        tick(4);
        chk(err_n, 1); chk(ign_n, 1); chk(stall, 0);
        t_self; t_ext(1'b0); t_ext(1'b1); t_ignore; t_packed; t_fault; t_stack;
        stop_test;
    end
    // Whole run needs fewer than two hundred cycles
    initial begin
        repeat (3000) @(posedge clk);
        bad_count++;
        stop_test;
    end
endmodule

// file: bench/fpes_glue_model.sv
// Interrupt controller and ignore latch glue facing the error pins
module fpes_glue_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       fp_error_out_n,
    input  wire logic       io_wr,
    input  wire logic [7:0] io_addr,
    input  wire logic       slow,
    output logic            maskable_irq_in,
    output logic            ignore_numeric_err_in_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic err_seen_q;
    ////////////////////////////////////////
    // Slow mode adds one cycle of controller latency
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            err_seen_q      <= 1'b0;
            maskable_irq_in <= 1'b0;
        end else begin
            err_seen_q      <= !fp_error_out_n;
            maskable_irq_in <= slow ? err_seen_q : !fp_error_out_n;
        end
    end
    // Error high wins, so a stray write cannot leave ignore stuck on
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ignore_numeric_err_in_n <= 1'b1;
        end else if (fp_error_out_n) begin
            ignore_numeric_err_in_n <= 1'b1;
        end else if (io_wr && io_addr == 8'hf0) begin
            ignore_numeric_err_in_n <= 1'b0;
        end
    end
endmodule

// file: verilog/fpes_core.sv
// Numeric exception reporting, stall and resume control of the core
//
// Operation
// RL1 - With the mode bit set, an unmasked exception vectors internally to 10h.
// RL2 - With the mode bit clear, no self-vectoring; the core waits for the external interrupt.
// RL3 - The error output goes low to report an unmasked floating-point exception.
// RL4 - With error asserted and ignore negated, execution stops until an interrupt.
// RL5 - Outside logic raises the maskable interrupt in answer to the error output.
// RL6 - Outside logic asserts ignore on an I/O write to port F0h.
// RL7 - With ignore sampled asserted, the pending exception is dropped and execution resumes.
// RL8 - Outside logic negates ignore once the error output negates.
// RL9 - A pending exception raises the error output at the next fp, packed or wait boundary.
// RL10 - Ignore counts only for error-sensitive fp, packed or wait instructions in mode 0.
// RL11 - Packed multimedia instructions never raise fp exceptions themselves.
// RL12 - Eight 64-bit multimedia registers alias the floating-point stack.
// RL13 - Multimedia faults use only the existing exception vectors.
// RL14 - Outside ignore latch is held negated after reset, set by the port write, cleared with error.
module fpes_core
    import fpes_pkg::*;
(
    input  wire logic                        clk,
    input  wire logic                        arst_n,
    input  wire logic                        numeric_error_mode_bit,
    input  wire logic                        ignore_numeric_err_in_n,
    input  wire logic                        maskable_irq_in,
    input  wire logic                        boundary_valid,
    input  wire fpes_class_e                 boundary_class,
    input  wire logic                        exc_raise,
    input  wire logic                        exc_masked,
    input  wire logic                        mm_fault,
    input  wire logic [7:0]                  mm_fault_vector,
    input  wire logic                        stack_wr_en,
    input  wire logic [FPES_STACK_IDX_W-1:0] stack_wr_idx,
    input  wire logic [FPES_MM_WIDTH-1:0]    stack_wr_data,
    input  wire logic [FPES_STACK_IDX_W-1:0] stack_rd_idx,
    output logic      [FPES_MM_WIDTH-1:0]    stack_rd_data,
    output logic                             fp_error_out_n,
    output logic                             exec_stall,
    output logic                             vector_valid,
    output logic      [7:0]                  vector_num
);
    ////////////////////////////////////////////////////////////////////////////
    logic        rst_s1_q;
    logic        rst_n_q;
    logic        ign_s1_q;
    logic        ign_n_q;
    logic        irq_s1_q;
    logic        irq_q;
    logic        pending_q;
    logic        err_q;
    fpes_state_e state_q;
    logic        sens_bnd;
    logic        fp_src;
    logic        raise_ok;
    logic        report;
    logic        go_self;
    logic        go_stall;
    logic        drop_pend;
    logic        stall_ign;
    logic        stall_irq;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // Pins are asynchronous to the core clock
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ign_s1_q <= 1'b1;
            ign_n_q  <= 1'b1;
            irq_s1_q <= 1'b0;
            irq_q    <= 1'b0;
        end else begin
            ign_s1_q <= ignore_numeric_err_in_n;
            ign_n_q  <= ign_s1_q;
            irq_s1_q <= maskable_irq_in;
            irq_q    <= irq_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Only real fp instructions may raise; packed classes cannot
    // Codes past the last class never occur; they decode as insensitive
    always_comb begin
        sens_bnd = 1'b0;
        fp_src   = 1'b0;
        if (boundary_valid) begin
            unique case (boundary_class)
                FPES_CLS_FP: begin
                    sens_bnd = 1'b1;                                    // RL9
                    fp_src   = 1'b1;                                    // RL11
                end
                FPES_CLS_MM_INT, FPES_CLS_MM_FLT, FPES_CLS_WAIT: begin
                    sens_bnd = 1'b1;                                    // RL9
                end
                default: begin
                    sens_bnd = 1'b0;
                end
            endcase
        end
    end

    assign raise_ok  = fp_src && exc_raise && !exc_masked;              // RL11
    assign report    = state_q == FPES_RUN && pending_q && sens_bnd;    // RL9
    assign go_self   = report && numeric_error_mode_bit;                // RL1
    assign go_stall  = report && !numeric_error_mode_bit && ign_n_q;    // RL2
    assign drop_pend = report && !numeric_error_mode_bit && !ign_n_q;   // RL10
    assign stall_ign = state_q == FPES_STALL && !ign_n_q;               // RL7
    assign stall_irq = state_q == FPES_STALL && ign_n_q && irq_q;       // RL4

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= FPES_RUN;
        end else begin
            unique case (state_q)
                FPES_RUN: begin
                    if (go_self) begin
                        state_q <= FPES_SELF;                           // RL1
                    end else if (go_stall) begin
                        state_q <= FPES_STALL;                          // RL2
                    end
                end
                FPES_STALL: begin
                    if (stall_ign || stall_irq) begin
                        state_q <= FPES_RUN;                            // RL4
                    end
                end
                FPES_SELF: begin
                    state_q <= FPES_RUN;
                end
            endcase
        end
    end

    // A raise in the same cycle as the drop is merged into it
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pending_q <= 1'b0;
        end else if (drop_pend || stall_ign || state_q == FPES_SELF) begin
            pending_q <= 1'b0;                                          // RL7
        end else if (state_q == FPES_RUN && raise_ok) begin
            pending_q <= 1'b1;                                          // RL3
        end
    end

    // Error survives an interrupt exit; only a sampled ignore clears it
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            err_q <= 1'b0;
        end else if (drop_pend || stall_ign) begin
            err_q <= 1'b0;                                              // RL7
        end else if (go_stall) begin
            err_q <= 1'b1;                                              // RL3
        end
    end

    // Vector goes out one cycle in self-handled mode; faults reuse existing vectors
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            vector_valid <= 1'b0;
            vector_num   <= 8'h00;
        end else if (state_q == FPES_SELF) begin
            vector_valid <= 1'b1;
            vector_num   <= FPES_FP_VECTOR;                             // RL1
        end else if (mm_fault) begin
            vector_valid <= 1'b1;
            vector_num   <= mm_fault_vector;                            // RL13
        end else begin
            vector_valid <= 1'b0;
            vector_num   <= 8'h00;
        end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            fp_error_out_n <= 1'b1;
        end else begin
            fp_error_out_n <= !err_q;                                   // RL3
        end
    end

    assign exec_stall = state_q == FPES_STALL;                          // RL4

    fpes_regstack u_stack (
        .clk     (clk),
        .rst_n   (rst_n_q),
        .wr_en   (stack_wr_en),
        .wr_idx  (stack_wr_idx),
        .wr_data (stack_wr_data),
        .rd_idx  (stack_rd_idx),
        .rd_data (stack_rd_data)                                        // RL12
    );

    ////////////////////////////////////////////////////////////////////////////
    // Self-vectoring path
    a_self_vector: assert property (@(posedge clk) disable iff (!rst_n_q) // RL1
        state_q == FPES_SELF |=> vector_valid && vector_num == FPES_FP_VECTOR)
        else $error("self vector not 10h");

    a_self_mode1: assert property (@(posedge clk) disable iff (!rst_n_q) // RL1
        state_q == FPES_SELF |-> $past(numeric_error_mode_bit))
        else $error("self vector without mode bit");

    a_self_once: assert property (@(posedge clk) disable iff (!rst_n_q) // RL1
        state_q == FPES_SELF |=> state_q == FPES_RUN && !pending_q)
        else $error("self vector not retired");

    a_no_self_mode0: assert property (@(posedge clk) disable iff (!rst_n_q) // RL2
        (!numeric_error_mode_bit && state_q == FPES_RUN) |=> state_q != FPES_SELF)
        else $error("self vector in mode 0");

    a_err_mode0: assert property (@(posedge clk) disable iff (!rst_n_q) // RL2
        $rose(err_q) |-> !$past(numeric_error_mode_bit))
        else $error("error output in mode 1");

    a_stall_no_vec: assert property (@(posedge clk) disable iff (!rst_n_q) // RL2
        (exec_stall && !mm_fault) |=> !vector_valid)
        else $error("vector while stalled");

    // Error output and stall
    a_err_follows: assert property (@(posedge clk) disable iff (!rst_n_q) // RL3
        $rose(err_q) |=> !fp_error_out_n)
        else $error("error output late");

    a_err_idle: assert property (@(posedge clk) disable iff (!rst_n_q) // RL3
        !err_q |=> fp_error_out_n)
        else $error("error output without cause");

    a_err_unmasked: assert property (@(posedge clk) disable iff (!rst_n_q) // RL3
        (!pending_q && exc_masked) |=> !pending_q)
        else $error("masked exception pended");

    a_stall_hold: assert property (@(posedge clk) disable iff (!rst_n_q) // RL4
        (exec_stall && ign_n_q && !irq_q) |=> exec_stall)
        else $error("stall left without cause");

    a_stall_err: assert property (@(posedge clk) disable iff (!rst_n_q) // RL4
        exec_stall |-> err_q && pending_q)
        else $error("stall without error");

    a_irq_exit: assert property (@(posedge clk) disable iff (!rst_n_q) // RL4
        (exec_stall && ign_n_q && irq_q) |=> !exec_stall && err_q && pending_q)
        else $error("interrupt exit lost error");

    a_irq_sync: assert property (@(posedge clk) disable iff (!rst_n_q) // RL4
        irq_q == $past(irq_s1_q))
        else $error("interrupt sync skipped");

    // Ignore handling and boundary reporting
    a_ignore_resume: assert property (@(posedge clk) disable iff (!rst_n_q) // RL7
        (exec_stall && !ign_n_q) |=> !exec_stall && !pending_q ##1 fp_error_out_n)
        else $error("ignore did not resume");

    a_ign_sync: assert property (@(posedge clk) disable iff (!rst_n_q) // RL7
        ign_n_q == $past(ign_s1_q))
        else $error("ignore sync skipped");

    a_boundary_report: assert property (@(posedge clk) disable iff (!rst_n_q) // RL9
        (state_q == FPES_RUN && pending_q && sens_bnd && !numeric_error_mode_bit && ign_n_q)
        |=> exec_stall ##1 !fp_error_out_n)
        else $error("no report at boundary");

    a_no_report_off: assert property (@(posedge clk) disable iff (!rst_n_q) // RL9
        (state_q == FPES_RUN && !sens_bnd) |=> state_q == FPES_RUN)
        else $error("report off a boundary");

    a_ignore_mode: assert property (@(posedge clk) disable iff (!rst_n_q) // RL10
        (state_q == FPES_RUN && pending_q && !sens_bnd) |=> pending_q)
        else $error("pending dropped off boundary");

    a_drop_clears: assert property (@(posedge clk) disable iff (!rst_n_q) // RL10
        (state_q == FPES_RUN && pending_q && sens_bnd && !numeric_error_mode_bit && !ign_n_q)
        |=> !pending_q && !err_q && !exec_stall ##1 fp_error_out_n)
        else $error("ignore at boundary not honoured");

    a_mode1_no_drop: assert property (@(posedge clk) disable iff (!rst_n_q) // RL10
        (state_q == FPES_RUN && pending_q && sens_bnd && numeric_error_mode_bit)
        |=> state_q == FPES_SELF && pending_q)
        else $error("ignore used in mode 1");

    // Packed instructions and fault vectors
    a_mm_no_raise: assert property (@(posedge clk) disable iff (!rst_n_q) // RL11
        (state_q == FPES_RUN && !pending_q && !fp_src) |=> !pending_q)
        else $error("packed op raised exception");

    a_pend_source: assert property (@(posedge clk) disable iff (!rst_n_q) // RL11
        $rose(pending_q) |-> $past(fp_src) && $past(exc_raise))
        else $error("pending without fp raise");

    a_mm_vector: assert property (@(posedge clk) disable iff (!rst_n_q) // RL13
        (mm_fault && state_q != FPES_SELF) |=> vector_num == $past(mm_fault_vector))
        else $error("fault vector altered");

    a_idle_vector: assert property (@(posedge clk) disable iff (!rst_n_q) // RL13
        (state_q != FPES_SELF && !mm_fault) |=> !vector_valid)
        else $error("vector without cause");

    c_stall: cover property (@(posedge clk) disable iff (!rst_n_q) $rose(exec_stall));
    c_ignore: cover property (@(posedge clk) disable iff (!rst_n_q) exec_stall && !ign_n_q);
    c_self: cover property (@(posedge clk) disable iff (!rst_n_q) state_q == FPES_SELF);
    c_irq_exit: cover property (@(posedge clk) disable iff (!rst_n_q) exec_stall && irq_q && ign_n_q);
    c_drop: cover property (@(posedge clk) disable iff (!rst_n_q)
        state_q == FPES_RUN && pending_q && sens_bnd && !numeric_error_mode_bit && !ign_n_q);
endmodule

// file: verilog/fpes_pkg.sv
// Shared constants and types for the floating-point error signalling block
package fpes_pkg;
    localparam logic [7:0] FPES_FP_VECTOR      = 8'h10;
    localparam logic [7:0] FPES_DNA_VECTOR     = 8'h07;
    localparam int         FPES_MM_REGS        = 8;
    localparam int         FPES_MM_WIDTH       = 64;
    localparam int         FPES_STACK_IDX_W    = 3;
    localparam logic [63:0] FPES_REG_RESET     = 64'h0000_0000_0000_0000;
    localparam logic [2:0]  FPES_TOP_RESET     = 3'h0;

    // Instruction class presented at each retirement boundary
    typedef enum logic [2:0] {
        FPES_CLS_OTHER,
        FPES_CLS_FP,
        FPES_CLS_MM_INT,
        FPES_CLS_MM_FLT,
        FPES_CLS_WAIT
    } fpes_class_e;

    typedef enum logic [1:0] {
        FPES_RUN,
        FPES_STALL,
        FPES_SELF
    } fpes_state_e;
endpackage

// file: verilog/fpes_regstack.sv
// Shared register stack for floating-point and multimedia values
module fpes_regstack
    import fpes_pkg::*;
(
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    input  wire logic                        wr_en,
    input  wire logic [FPES_STACK_IDX_W-1:0] wr_idx,
    input  wire logic [FPES_MM_WIDTH-1:0]    wr_data,
    input  wire logic [FPES_STACK_IDX_W-1:0] rd_idx,
    output logic      [FPES_MM_WIDTH-1:0]    rd_data
);
    logic [FPES_MM_WIDTH-1:0] mem_q [FPES_MM_REGS];

    // One physical array serves both views, so a state save covers both
    genvar gi;
    generate
        for (gi = 0; gi < FPES_MM_REGS; gi++) begin : g_ent
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    mem_q[gi] <= FPES_REG_RESET;
                end else if (wr_en && wr_idx == FPES_STACK_IDX_W'(gi)) begin
                    mem_q[gi] <= wr_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= FPES_REG_RESET;
        end else begin
            rd_data <= mem_q[rd_idx];
        end
    end
endmodule
